/* File: design/uic_level_cross.v */
// detects a fifo fill level passing through a trigger level
`timescale 1ns/100ps
`include "uic_map.vh"
module uic_level_cross #(
  parameter DEPTH_W = 5,
  parameter IS_TX   = 0
) (
  input  wire               clock_i,
  input  wire               reset_i,
  input  wire [DEPTH_W-1:0] level_i,
  input  wire [2:0]         select_i,
  output reg                crossed_o
);
  reg  [DEPTH_W-1:0] level_q;
  reg  [DEPTH_W-1:0] trig;
  wire [DEPTH_W+2:0] full = {3'h0, {DEPTH_W{1'b1}}} + {{(DEPTH_W+2){1'b0}}, 1'b1};
  wire [DEPTH_W+2:0] eighth  = full >> 3;
  wire [DEPTH_W+2:0] quarter = full >> 2;
  wire [DEPTH_W+2:0] half    = full >> 1;
  wire [DEPTH_W+2:0] three_q = half + quarter;
  wire [DEPTH_W+2:0] seven_e = three_q + eighth;

  always @* begin
    case (select_i)
      3'h0: trig = eighth[DEPTH_W-1:0];
      3'h1: trig = quarter[DEPTH_W-1:0];
      3'h3: trig = three_q[DEPTH_W-1:0];
      3'h4: trig = seven_e[DEPTH_W-1:0];
      default: trig = half[DEPTH_W-1:0];
    endcase
  end

  // edge through the trigger, not the level itself
  always @(posedge clock_i) begin
    if (reset_i) begin
      level_q   <= {DEPTH_W{1'b0}};
      crossed_o <= 1'b0;
    end else begin
      level_q <= level_i;
      if (IS_TX != 0)
        crossed_o <= (level_q > trig) && (level_i <= trig);  // see RQ11
      else
        crossed_o <= (level_q < trig) && (level_i >= trig);  // see RQ11
    end
  end
endmodule

/* File: design/uic_map.vh */
// register map and field constants of the serial-port interrupt status and clear block
// What the document requires
// RQ1: raw status read returns unmasked state of every source; writes ignored.
// RQ2: raw flags in bits 10..4: overrun, break, parity, framing, timeout, tx, rx; reset 0.
// RQ3: raw status bits 3:0 are read-only and read as all ones.
// RQ4: masked status read returns each raw flag gated by its mask bit; writes ignored.
// RQ5: masked flags in bits 10..4, same order; all masked bits reset to 0.
// RQ6: writing 1 to a clear bit clears that raw flag and its masked flag.
// RQ7: writing 0 to a clear bit leaves the flag unchanged.
// RQ8: clear bits 10..4 map to the seven sources in order; write-one-to-clear.
// RQ9: software leaves bits 31:11 alone and treats their read value as undefined.
// RQ10: mask bit 1 routes the raw flag to the interrupt output; 0 blocks it.
// RQ11: tx and rx flags set when fill level passes through trigger level, not at it.
// RQ12: the single interrupt output is high whenever any masked bit is 1; here irq_o is registered and follows one clock later.
`ifndef UIC_MAP_VH
`define UIC_MAP_VH
`define UIC_OFS_FIFO_LEVEL   12'h034
`define UIC_OFS_MASK         12'h038
`define UIC_OFS_RAW          12'h03C
`define UIC_OFS_MASKED       12'h040
`define UIC_OFS_CLEAR        12'h044
`define UIC_FLAG_LSB         4
`define UIC_FLAG_MSB         10
`define UIC_NUM_SRC          7
`define UIC_SRC_RX           0
`define UIC_SRC_TX           1
`define UIC_RAW_RSVD_VAL     4'hF
`define UIC_LEVEL_RST        6'h12
`define UIC_RESP_OKAY        2'h0
`define UIC_RESP_SLVERR      2'h2
`endif

/* File: design/uic_top.v */
// interrupt status, mask and clear registers over an axi4-lite slave
`timescale 1ns/100ps
`include "uic_map.vh"
module uic_top #(
  parameter DEPTH_W = 5
) (
  input  wire               clock_i,
  input  wire               reset_i,
  input  wire               overrun_ev_i,
  input  wire               break_ev_i,
  input  wire               parity_ev_i,
  input  wire               framing_ev_i,
  input  wire               rx_timeout_ev_i,
  input  wire [DEPTH_W-1:0] tx_level_i,
  input  wire [DEPTH_W-1:0] rx_level_i,
  input  wire [11:0]        s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output reg                s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output reg                s_axi_wready,
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [11:0]        s_axi_araddr,
  input  wire               s_axi_arvalid,
  output reg                s_axi_arready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  output reg                irq_o
);
  localparam N = `UIC_NUM_SRC;

  reg  [N-1:0]     raw_q;
  reg  [N-1:0]     irq_mask_q;
  reg  [5:0]       level_sel_q;
  reg  [11:0]      awaddr_q;
  reg              aw_have_q;
  reg  [31:0]      wdata_q;
  reg  [3:0]       wstrb_q;
  reg              w_have_q;
  wire             tx_cross;
  wire             rx_cross;
  wire [N-1:0]     event_set;
  wire [N-1:0]     masked;
  wire             wr_go;
  wire [N-1:0]     clr_bits;
  wire             clr_lane0;
  wire             clr_lane1;
  reg  [31:0]      rd_val;
  reg              rd_ok;
  reg              wr_ok;
  reg              hit_clear;
  reg              hit_mask;
  reg              hit_level;

  uic_level_cross #(.DEPTH_W(DEPTH_W), .IS_TX(1)) u_tx_cross (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .level_i   (tx_level_i),
    .select_i  (level_sel_q[2:0]),
    .crossed_o (tx_cross)
  );

  uic_level_cross #(.DEPTH_W(DEPTH_W), .IS_TX(0)) u_rx_cross (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .level_i   (rx_level_i),
    .select_i  (level_sel_q[5:3]),
    .crossed_o (rx_cross)
  );

  // source order from bit 10 down to bit 4
  assign event_set = {overrun_ev_i, break_ev_i, parity_ev_i, framing_ev_i,
                      rx_timeout_ev_i, tx_cross, rx_cross};  // see RQ2
  assign masked    = raw_q & irq_mask_q;  // see RQ10

  assign wr_go     = aw_have_q && w_have_q && !s_axi_bvalid;
  assign clr_lane0 = wstrb_q[0];
  assign clr_lane1 = wstrb_q[1];
  // only ones in written byte lanes clear; zeros leave flags alone
  assign clr_bits  = (wr_go && hit_clear) ?
                     ({{3{clr_lane1}}, {4{clr_lane0}}} &
                      wdata_q[`UIC_FLAG_MSB:`UIC_FLAG_LSB]) : {N{1'b0}};  // see RQ6 RQ7 RQ8

  // write decode; both status registers answer okay and keep their value
  always @* begin
    wr_ok     = 1'b1;
    hit_clear = 1'b0;
    hit_mask  = 1'b0;
    hit_level = 1'b0;
    case (awaddr_q)
      `UIC_OFS_CLEAR: begin
        hit_clear = 1'b1;  // see RQ8
      end
      `UIC_OFS_MASK: begin
        hit_mask = 1'b1;
      end
      `UIC_OFS_FIFO_LEVEL: begin
        hit_level = 1'b1;
      end
      `UIC_OFS_RAW: begin
        wr_ok = 1'b1;  // see RQ1
      end
      `UIC_OFS_MASKED: begin
        wr_ok = 1'b1;  // see RQ4
      end
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_flag
      // a new event in the clearing cycle wins
      always @(posedge clock_i) begin
        if (reset_i)
          raw_q[g] <= 1'b0;  // see RQ2
        else if (event_set[g])
          raw_q[g] <= 1'b1;
        else if (clr_bits[g])
          raw_q[g] <= 1'b0;  // see RQ6
      end
    end
  endgenerate

  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `UIC_OFS_RAW: begin
        rd_val[`UIC_FLAG_MSB:`UIC_FLAG_LSB] = raw_q;  // see RQ1
        rd_val[3:0] = `UIC_RAW_RSVD_VAL;  // see RQ3
      end
      `UIC_OFS_MASKED: begin
        rd_val[`UIC_FLAG_MSB:`UIC_FLAG_LSB] = masked;  // see RQ4 RQ5
      end
      `UIC_OFS_MASK: begin
        rd_val[`UIC_FLAG_MSB:`UIC_FLAG_LSB] = irq_mask_q;
      end
      `UIC_OFS_FIFO_LEVEL: begin
        rd_val[5:0] = level_sel_q;
      end
      `UIC_OFS_CLEAR: begin
        rd_val = 32'h0000_0000;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // mask and trigger select change only in the byte lanes the strobe enables
  always @(posedge clock_i) begin
    if (reset_i) begin
      irq_mask_q  <= {N{1'b0}};
      level_sel_q <= `UIC_LEVEL_RST;
    end else if (wr_go) begin
      if (hit_mask && wstrb_q[0])
        irq_mask_q[3:0] <= wdata_q[7:4];  // see RQ10
      if (hit_mask && wstrb_q[1])
        irq_mask_q[6:4] <= wdata_q[10:8];  // see RQ10
      if (hit_level && wstrb_q[0])
        level_sel_q <= wdata_q[5:0];  // see RQ11
    end
  end

  always @(posedge clock_i) begin
    if (reset_i)
      irq_o <= 1'b0;
    else
      irq_o <= |masked;  // see RQ12
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      awaddr_q      <= 12'h000;
      aw_have_q     <= 1'b0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      w_have_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `UIC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `UIC_RESP_OKAY;
    end else begin
      // write address and data are latched independently
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q  <= {s_axi_awaddr[11:2], 2'b00};
        aw_have_q <= 1'b1;
      end
      s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `UIC_RESP_OKAY : `UIC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? `UIC_RESP_OKAY : `UIC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

/* File: testbench/uic_bench.sv */
// self-checking bench of the interrupt status and clear block
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value %0t: %h not %h", $time, a, e); end end
module uic_bench;
  logic clock_i = 0, reset_i = 1, irq_o;
  logic overrun_ev_i = 0, break_ev_i = 0, parity_ev_i = 0, framing_ev_i = 0, rx_timeout_ev_i = 0;
  logic [4:0] tx_level_i = 5'h1F, rx_level_i = 5'h00;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [6:0] raw_m = 0, msk_m = 0, r7;
  logic [2:0] sel;
  integer miscompares = 0, checked = 0, cycles = 0, seed = 82, i, t;
  always #5 clock_i = ~clock_i;
  uic_top #(.DEPTH_W(5)) DUT (.clock_i, .reset_i, .overrun_ev_i, .break_ev_i, .parity_ev_i,
    .framing_ev_i, .rx_timeout_ev_i, .tx_level_i, .rx_level_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_o);
  uic_host host (.clock_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  task rchk(input [11:0] a, input [31:0] e);
    host.rd(a, d, r);
    `CHK(d, e)
    `CHK(r, 2'h0)
  endtask
  // one-cycle events; levels cross the default half-way trigger and go back
  task pulse(input [4:0] ev, input lv);
    {overrun_ev_i, break_ev_i, parity_ev_i, framing_ev_i, rx_timeout_ev_i} <= ev;
    if (lv) begin
      rx_level_i <= 5'h1F;
      tx_level_i <= 5'h00;
    end
    @(posedge clock_i);
    {overrun_ev_i, break_ev_i, parity_ev_i, framing_ev_i, rx_timeout_ev_i} <= 5'h0;
    rx_level_i <= 5'h00;
    tx_level_i <= 5'h1F;
    repeat (3) @(posedge clock_i);
    raw_m = raw_m | {ev, lv, lv};
  endtask
  task finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge clock_i);
    reset_i <= 1'h0;
    @(posedge clock_i);
    rchk(12'h03C, 32'hF);
    rchk(12'h040, 32'h0);
    host.rd(12'h0F0, d, r);
    `CHK(r, 2'h2)
    rchk(12'h044, 32'h0);
    for (i = 0; i < 12; i++) begin
      pulse(5'($random(seed)), i[0]);
      host.wr(i[1] ? 12'h040 : 12'h03C, $random(seed), r);
      `CHK(r, 2'h0)
      rchk(12'h03C, {21'h0, raw_m, 4'hF});
      r7 = 7'($random(seed));
      host.wr(12'h038, {21'h0, r7, 4'h0}, r);
      msk_m = r7;
      rchk(12'h038, {21'h0, r7, 4'h0});
      repeat (2) @(posedge clock_i);
      rchk(12'h040, {21'h0, raw_m & msk_m, 4'h0});
      `CHK(irq_o, |(raw_m & msk_m))
      r7 = 7'($random(seed));
      host.wr(12'h044, {21'h0, r7, 4'h0}, r);
      raw_m = raw_m & ~r7;
      rchk(12'h03C, {21'h0, raw_m, 4'hF});
    end
    // eight random trigger selects: level sits next to the trigger, then steps onto it
    for (i = 0; i < 8; i++) begin
      sel = 3'($random(seed));
      host.wr(12'h034, {26'h0, sel, sel}, r);
      rchk(12'h034, {26'h0, sel, sel});
      t = (sel == 0) ? 4 : (sel == 1) ? 8 : (sel == 3) ? 24 : (sel == 4) ? 28 : 16;
      rx_level_i <= 5'(t - 1);
      tx_level_i <= 5'(t + 1);
      repeat (2) @(posedge clock_i);
      host.wr(12'h044, 32'h30, r);
      raw_m = raw_m & 7'h7C;
      rchk(12'h03C, {21'h0, raw_m, 4'hF});
      rx_level_i <= 5'(t);
      tx_level_i <= 5'(t);
      repeat (3) @(posedge clock_i);
      raw_m = raw_m | 7'h03;
      rchk(12'h03C, {21'h0, raw_m, 4'hF});
      host.wr(12'h044, 32'h30, r);
      raw_m = raw_m & 7'h7C;
      repeat (3) @(posedge clock_i);
      rchk(12'h03C, {21'h0, raw_m, 4'hF});
      rx_level_i <= 5'h00;
      tx_level_i <= 5'h1F;
      @(posedge clock_i);
    end
    // reset in mid-run with flags and mask set
    pulse(5'h1F, 1'b1);
    reset_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'h0;
    @(posedge clock_i);
    raw_m = 0;
    msk_m = 0;
    `CHK(irq_o, 1'b0)
    rchk(12'h03C, 32'hF);
    rchk(12'h040, 32'h0);
    rchk(12'h038, 32'h0);
    rchk(12'h034, 32'h12);
    finish_test;
  end
endmodule

/* File: testbench/uic_host.sv */
// bus master model on the processor side
`timescale 1ns/100ps
module uic_host (
  input  wire        clock_i,
  output reg  [11:0] s_axi_awaddr,
  output reg         s_axi_awvalid,
  input  wire        s_axi_awready,
  output reg  [31:0] s_axi_wdata,
  output reg  [3:0]  s_axi_wstrb,
  output reg         s_axi_wvalid,
  input  wire        s_axi_wready,
  input  wire [1:0]  s_axi_bresp,
  input  wire        s_axi_bvalid,
  output reg         s_axi_bready,
  output reg  [11:0] s_axi_araddr,
  output reg         s_axi_arvalid,
  input  wire        s_axi_arready,
  input  wire [31:0] s_axi_rdata,
  input  wire [1:0]  s_axi_rresp,
  input  wire        s_axi_rvalid,
  output reg         s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hF;
  end
  // bits 31:11 always written as zero
  task wr(input [11:0] a, input [31:0] d, output [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {21'h0, d[10:0]};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clock_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    // one idle edge before the next request may raise bready again
    @(posedge clock_i);
  endtask
  task rd(input [11:0] a, output [31:0] d, output [1:0] r);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clock_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge clock_i);
  endtask
endmodule

/* File: testbench/uic_monitor.sv */
// checker on the bus ports of the interrupt status block
`timescale 1ns/100ps
module uic_monitor (
  input wire        clock_i,
  input wire        reset_i,
  input wire [11:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence s_rd(a); s_axi_arvalid && s_axi_arready && s_axi_araddr == a; endsequence
  property p_aw; $rose(s_axi_awvalid) |=> s_axi_awready; endproperty
  property p_b; s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
  property p_ar; $rose(s_axi_arvalid) |=> s_axi_arready; endproperty
  property p_r; s_axi_arready |=> s_axi_rvalid; endproperty
  property p_raw; s_rd(12'h03C) |=> s_axi_rdata[3:0] == 4'hF; endproperty
  property p_msk; s_rd(12'h040) |=> s_axi_rdata[3:0] == 4'h0; endproperty
  property p_bad; s_rd(12'h0F0) |=> s_axi_rresp == 2'h2; endproperty
  property p_ro; s_axi_awvalid && s_axi_awready && (s_axi_awaddr == 12'h03C ||
    s_axi_awaddr == 12'h040) |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == 2'h0); endproperty
  a_aw: assert property (p_aw) else $error("late awready");
  a_b: assert property (p_b) else $error("late bvalid");
  a_ar: assert property (p_ar) else $error("late arready");
  a_r: assert property (p_r) else $error("late rvalid");
  a_raw: assert property (p_raw) else $error("raw low bits");
  a_msk: assert property (p_msk) else $error("masked low bits");
  a_bad: assert property (p_bad) else $error("unmapped read");
  a_ro: assert property (p_ro) else $error("read-only write");
endmodule
bind uic_top uic_monitor u_mon (.clock_i, .reset_i, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);
